// ### hdl/iorps_regs.svh
`ifndef IORPS_REGS_SVH
`define IORPS_REGS_SVH

// Timing
`define IORPS_CLK_PERIOD_NS 8
`define IORPS_PHASE_NS 250
`define IORPS_PHASE_CYC ((`IORPS_PHASE_NS + `IORPS_CLK_PERIOD_NS - 1) / `IORPS_CLK_PERIOD_NS)

// Phase counter codes (phase one .. phase four)
`define IORPS_PH1 2'h0
`define IORPS_PH4 2'h3

// Request source positions, highest priority first
`define IORPS_SRC_N 5
`define IORPS_SRC_DATA_CH 0
`define IORPS_SRC_CLOCK 1
`define IORPS_SRC_AUTO_PRI 2
`define IORPS_SRC_PROG_INT 3
`define IORPS_SRC_IO_INSTR 4

// Word width moved through the accumulator
`define IORPS_WORD_W 18

// Register byte offsets
`define IORPS_CTRL_OFF 8'h00
`define IORPS_STATUS_OFF 8'h04
`define IORPS_COUNT_OFF 8'h08
`define IORPS_ABORT_OFF 8'h0C

// CTRL fields and reset value
`define IORPS_CTRL_RUN_BIT 0
`define IORPS_CTRL_EN_LSB 8
`define IORPS_CTRL_RST 32'h00001F01

// STATUS fields
`define IORPS_ST_PHASE_LSB 0
`define IORPS_ST_FIRST_LSB 4
`define IORPS_ST_SYNC_LSB 12
`define IORPS_ST_GRANT_BIT 20
`define IORPS_ST_HOLD_BIT 21

`endif

// ### hdl/iorps_pkg.sv
package iorps_pkg;
	typedef logic [4:0] iorps_src_t;
	typedef logic [1:0] iorps_phase_cnt_t;
	typedef enum logic [3:0] {
		IORPS_T1 = 4'h1,
		IORPS_T2 = 4'h2,
		IORPS_T3 = 4'h4,
		IORPS_T4 = 4'h8
	} iorps_phase_t;
endpackage

// ### hdl/iorps_phase_gen.sv
`timescale 1ns/10ps
`include "iorps_regs.svh"
module iorps_phase_gen import iorps_pkg::*; #(
	parameter int PHASE_CYC = `IORPS_PHASE_CYC
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic run,
	input wire logic hold,
	output iorps_phase_cnt_t phase_cnt,
	output logic phase_tick
);
	logic [7:0] div_reg;
	logic [7:0] div_next;
	iorps_phase_cnt_t cnt_reg;
	iorps_phase_cnt_t cnt_next;
	logic tick_reg;
	logic tick_next;

	// Tick marks the first cycle of a newly entered phase
	always_comb begin
		div_next = div_reg;
		cnt_next = cnt_reg;
		tick_next = 1'b0;
		if (run && !hold) begin
			if (div_reg == 8'(PHASE_CYC - 1)) begin
				div_next = 8'h00;
				cnt_next = cnt_reg + 2'h1;
				tick_next = 1'b1;
			end else begin
				div_next = div_reg + 8'h01;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_reg <= 8'h00;
			cnt_reg <= 2'h3;
			tick_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign phase_cnt = cnt_reg;
	assign phase_tick = tick_reg;
endmodule

// ### hdl/iorps_prio_pick.sv
`timescale 1ns/10ps
module iorps_prio_pick #(
	parameter int N = 5
) (
	input wire logic [N-1:0] req,
	output logic [N-1:0] keep
);
	logic [N:0] above;

	// Bit 0 is highest; each bit survives only if nothing above it is set
	assign above[0] = 1'b0;
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_pick
			assign keep[i] = req[i] & ~above[i];
			assign above[i+1] = above[i] | req[i];
		end
	endgenerate
endmodule

// ### hdl/iorps_top.sv
// Contract
// - Phase clock steps every 250 ns, a 4 MHz rate.
// - Each step advances a 2-bit counter decoded into four phases, 1 MHz cycle.
// - Phase one is the bus sync phase devices align requests to.
// - Phase clock runs freely except holding for memory on multicycle or single-out transfers.
// - Priority: data channel, clock, auto priority, program interrupt, I/O instruction.
// - All first-stage request flops sample their inputs at phase four, any may set.
// - One phase later, at phase one, second-stage sync flops load.
// - Higher first-stage request clears all lower ones before the second-stage load.
// - A set sync flop stays set until its transfer finishes.
// - Data channel raises memory request, granted once the CPU reference finishes.
// - Data channel keeps memory precedence over CPU until its transfer completes.
// - Program transfers move one 18-bit word through the accumulator.
// - I/O instruction completion clears both its first and second stage flops.
`timescale 1ns/10ps
`include "iorps_regs.svh"
module iorps_top import iorps_pkg::*; #(
	parameter int PHASE_CYC = `IORPS_PHASE_CYC,
	parameter int WORD_W = `IORPS_WORD_W,
	parameter int COUNT_W = 16
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Requests from devices and the CPU
	input wire logic data_channel_request,
	input wire logic clock_request,
	input wire logic auto_priority_interrupt_request,
	input wire logic program_interrupt_request,
	input wire logic io_instruction_request,
	input wire logic [4:0] xfer_done,
	// Memory path
	input wire logic mem_wait,
	input wire logic data_channel_multicycle,
	input wire logic data_channel_single_out,
	input wire logic cpu_mem_busy,
	// Accumulator word path
	input wire logic [WORD_W-1:0] ac_word,
	input wire logic [WORD_W-1:0] device_word,
	// Outputs
	output logic [3:0] phase_onehot,
	output logic io_sync_pulse,
	output logic [4:0] sync_grant,
	output logic io_mem_request,
	output logic io_mem_grant,
	output logic cpu_mem_hold,
	output logic [WORD_W-1:0] io_bus_word,
	output logic [WORD_W-1:0] ac_return_word
);
	function automatic iorps_phase_t dec_phase(input iorps_phase_cnt_t c);
		iorps_phase_t p;
		p = IORPS_T1;
		unique case (c)
			2'h0: p = IORPS_T1;
			2'h1: p = IORPS_T2;
			2'h2: p = IORPS_T3;
			2'h3: p = IORPS_T4;
		endcase
		return p;
	endfunction

	iorps_phase_cnt_t phase_cnt;
	logic phase_tick;
	logic ph_hold;
	logic run;
	iorps_src_t src_en;
	iorps_src_t req_in;
	iorps_src_t first_keep;

	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;
	iorps_src_t abort_reg;
	iorps_src_t abort_next;
	logic [COUNT_W-1:0] count_reg;
	logic [COUNT_W-1:0] count_next;

	iorps_src_t first_reg;
	iorps_src_t first_next;
	iorps_src_t sync_reg;
	iorps_src_t sync_next;
	logic [3:0] phase_oh_reg;
	logic [3:0] phase_oh_next;
	logic io_sync_reg;
	logic io_sync_next;
	logic mreq_reg;
	logic mreq_next;
	logic mgrant_reg;
	logic mgrant_next;
	logic chold_reg;
	logic chold_next;
	logic [WORD_W-1:0] bus_word_reg;
	logic [WORD_W-1:0] bus_word_next;
	logic [WORD_W-1:0] ret_word_reg;
	logic [WORD_W-1:0] ret_word_next;

	logic sample_t4;
	logic load_t1;
	logic settle_t4;
	logic wr_acc;
	iorps_src_t finish;

	assign run = ctrl_reg[`IORPS_CTRL_RUN_BIT];
	assign src_en = ctrl_reg[`IORPS_CTRL_EN_LSB +: 5];
	// Memory wait stalls the phases only for these data channel transfers
	assign ph_hold = mem_wait && sync_reg[`IORPS_SRC_DATA_CH] &&
		(data_channel_multicycle || data_channel_single_out);

	iorps_phase_gen #(
		.PHASE_CYC(PHASE_CYC)
	) u_phase (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.run(run),
		.hold(ph_hold),
		.phase_cnt(phase_cnt),
		.phase_tick(phase_tick)
	);

	assign req_in = {io_instruction_request, program_interrupt_request,
		auto_priority_interrupt_request, clock_request, data_channel_request};

	iorps_prio_pick #(
		.N(`IORPS_SRC_N)
	) u_pick (
		.req(first_reg),
		.keep(first_keep)
	);

	assign sample_t4 = phase_tick && (phase_cnt == `IORPS_PH4);
	assign settle_t4 = !phase_tick && (phase_cnt == `IORPS_PH4);
	assign load_t1 = phase_tick && (phase_cnt == `IORPS_PH1);
	assign wr_acc = psel && penable && pready_reg && pwrite;
	assign finish = xfer_done | abort_reg;

	// Two-stage request synchronizer
	always_comb begin
		first_next = first_reg;
		sync_next = sync_reg;
		count_next = count_reg;
		// Completion clears first, so a same-cycle sample still sets
		first_next = first_next & ~finish;
		sync_next = sync_next & ~finish;
		if (sample_t4) begin
			first_next = first_next | (req_in & src_en);
		end else if (settle_t4) begin
			// Lower requests drop out, and a completion in this window still clears its own bit
			first_next = first_next & first_keep;
		end
		if (load_t1 && sync_reg == 5'h00) begin
			sync_next = first_keep;
			if (first_keep != 5'h00) begin
				count_next = count_reg + COUNT_W'(1);
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			first_reg <= 5'h00;
			sync_reg <= 5'h00;
			count_reg <= '0;
		end else begin
			first_reg <= first_next;
			sync_reg <= sync_next;
			count_reg <= count_next;
		end
	end

	// Phase, memory arbitration and word path outputs
	always_comb begin
		phase_oh_next = dec_phase(phase_cnt);
		io_sync_next = load_t1;
		mreq_next = sync_reg[`IORPS_SRC_DATA_CH];
		mgrant_next = 1'b0;
		if (sync_reg[`IORPS_SRC_DATA_CH]) begin
			mgrant_next = mgrant_reg || !cpu_mem_busy;
		end
		chold_next = sync_reg[`IORPS_SRC_DATA_CH];
		bus_word_next = bus_word_reg;
		ret_word_next = ret_word_reg;
		if (sync_reg[`IORPS_SRC_IO_INSTR]) begin
			bus_word_next = ac_word;
		end
		if (xfer_done[`IORPS_SRC_IO_INSTR] && sync_reg[`IORPS_SRC_IO_INSTR]) begin
			ret_word_next = device_word;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase_oh_reg <= 4'h8;
			io_sync_reg <= 1'b0;
			mreq_reg <= 1'b0;
			mgrant_reg <= 1'b0;
			chold_reg <= 1'b0;
			bus_word_reg <= '0;
			ret_word_reg <= '0;
		end else begin
			phase_oh_reg <= phase_oh_next;
			io_sync_reg <= io_sync_next;
			mreq_reg <= mreq_next;
			mgrant_reg <= mgrant_next;
			chold_reg <= chold_next;
			bus_word_reg <= bus_word_next;
			ret_word_reg <= ret_word_next;
		end
	end

	// APB slave: read data and status prepared in setup, one-cycle access
	always_comb begin
		ctrl_next = ctrl_reg;
		abort_next = 5'h00;
		prdata_next = prdata_reg;
		pready_next = psel && !penable;
		pslverr_next = 1'b0;
		if (psel && !penable) begin
			prdata_next = 32'h00000000;
			unique case (paddr)
				`IORPS_CTRL_OFF: prdata_next = ctrl_reg;
				`IORPS_STATUS_OFF: begin
					prdata_next[`IORPS_ST_PHASE_LSB +: 2] = phase_cnt;
					prdata_next[`IORPS_ST_FIRST_LSB +: 5] = first_reg;
					prdata_next[`IORPS_ST_SYNC_LSB +: 5] = sync_reg;
					prdata_next[`IORPS_ST_GRANT_BIT] = mgrant_reg;
					prdata_next[`IORPS_ST_HOLD_BIT] = ph_hold;
				end
				`IORPS_COUNT_OFF: prdata_next[COUNT_W-1:0] = count_reg;
				`IORPS_ABORT_OFF: prdata_next = 32'h00000000;
				default: pslverr_next = 1'b1;
			endcase
		end
		if (wr_acc && !pslverr_reg) begin
			if (paddr == `IORPS_CTRL_OFF) begin
				ctrl_next = 32'h00000000;
				ctrl_next[`IORPS_CTRL_RUN_BIT] = pwdata[`IORPS_CTRL_RUN_BIT];
				ctrl_next[`IORPS_CTRL_EN_LSB +: 5] = pwdata[`IORPS_CTRL_EN_LSB +: 5];
			end
			if (paddr == `IORPS_ABORT_OFF) begin
				abort_next = pwdata[4:0];
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_reg <= `IORPS_CTRL_RST;
			abort_reg <= 5'h00;
			prdata_reg <= 32'h00000000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			abort_reg <= abort_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign phase_onehot = phase_oh_reg;
	assign io_sync_pulse = io_sync_reg;
	assign sync_grant = sync_reg;
	assign io_mem_request = mreq_reg;
	assign io_mem_grant = mgrant_reg;
	assign cpu_mem_hold = chold_reg;
	assign io_bus_word = bus_word_reg;
	assign ac_return_word = ret_word_reg;
endmodule

// ### test/iorps_top_assertions.sv
`timescale 1ns/10ps
module iorps_top_assertions #(
	parameter int PHASE_CYC = 32,
	parameter int WORD_W = 18
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [4:0] xfer_done,
	input wire logic mem_wait,
	input wire logic data_channel_multicycle,
	input wire logic data_channel_single_out,
	input wire logic cpu_mem_busy,
	input wire logic [WORD_W-1:0] ac_word,
	input wire logic [3:0] phase_onehot,
	input wire logic io_sync_pulse,
	input wire logic [4:0] sync_grant,
	input wire logic io_mem_request,
	input wire logic io_mem_grant,
	input wire logic cpu_mem_hold,
	input wire logic [WORD_W-1:0] io_bus_word
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic [3:0] prev_reg, prev_next;
	int unsigned gap_reg, gap_next;
	logic [4:0] abort_seen;
	// Sources cleared by a software abort accepted at this edge
	assign abort_seen = (psel && penable && pready && pwrite && paddr == 8'h0C) ? pwdata[4:0] : 5'h00;
	// Cycles since the last phase step
	always_comb begin
		prev_next = phase_onehot;
		gap_next = (phase_onehot != prev_reg) ? 0 : gap_reg + 1;
	end
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			prev_reg <= 4'h8;
			gap_reg <= PHASE_CYC;
		end else begin
			prev_reg <= prev_next;
			gap_reg <= gap_next;
		end
	end
	sequence hold_s;
		mem_wait && sync_grant[0] && (data_channel_multicycle || data_channel_single_out);
	endsequence
	sequence dch_up_s;
		sync_grant[0] ##1 sync_grant[0];
	endsequence
	phase_decode_a: assert property ($onehot(phase_onehot)) else $error("phase not one-hot");
	phase_order_a: assert property ($changed(phase_onehot) |->
		phase_onehot == {prev_reg[2:0], prev_reg[3]}) else $error("phase order");
	phase_gap_a: assert property ($changed(phase_onehot) |-> gap_reg >= PHASE_CYC - 1)
		else $error("phase too short");
	grant_single_a: assert property ($onehot0(sync_grant)) else $error("two grants");
	grant_at_sync_a: assert property ($rose(|sync_grant) |-> io_sync_pulse && phase_onehot == 4'h1)
		else $error("grant off phase one");
	grant_holds_a: assert property ((|sync_grant) && !(|(sync_grant & (xfer_done | $past(abort_seen)))) |=>
		sync_grant == $past(sync_grant)) else $error("grant dropped");
	grant_clear_a: assert property (|(sync_grant & (xfer_done | $past(abort_seen))) |=> sync_grant == 5'h00)
		else $error("grant not cleared");
	mem_request_a: assert property (1'b1 |=> io_mem_request == $past(sync_grant[0]))
		else $error("mem request");
	mem_grant_a: assert property ($rose(io_mem_grant) |-> $past(sync_grant[0] && !cpu_mem_busy))
		else $error("mem grant early");
	cpu_hold_a: assert property (dch_up_s |-> cpu_mem_hold) else $error("cpu not held");
	phase_hold_a: assert property (hold_s ##1 hold_s |=> $stable(phase_onehot))
		else $error("phase ran in hold");
	bus_word_a: assert property (sync_grant[4] ##1 sync_grant[4] |-> io_bus_word == $past(ac_word))
		else $error("bus word");
endmodule
bind iorps_top iorps_top_assertions #(.PHASE_CYC(PHASE_CYC), .WORD_W(WORD_W)) chk (.ref_clk, .sys_rst,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pready,
	.xfer_done, .mem_wait, .data_channel_multicycle, .data_channel_single_out, .cpu_mem_busy, .ac_word,
	.phase_onehot, .io_sync_pulse, .sync_grant, .io_mem_request, .io_mem_grant, .cpu_mem_hold, .io_bus_word);

// ### test/iorps_far_model.sv
`timescale 1ns/10ps
module iorps_far_model (
	input wire logic ref_clk,
	input wire logic io_sync_pulse,
	input wire logic [4:0] sync_grant,
	input wire logic [4:0] want,
	input wire logic [7:0] lat,
	output logic [4:0] req,
	output logic [4:0] done
);
	logic [7:0] cnt;
	logic fin;
	wire logic fire = (sync_grant != 5'h00) && !fin && cnt >= lat;
	initial begin
		req = 5'h00;
		done = 5'h00;
		cnt = 8'h00;
		fin = 1'b0;
	end
	// Requests rise at the sync phase, held until the transfer ends
	always @(posedge ref_clk) begin
		req <= (req | (io_sync_pulse ? want : 5'h00)) & ~(fire ? sync_grant : 5'h00);
		done <= fire ? sync_grant : 5'h00;
		fin <= (sync_grant != 5'h00) && (fin || fire);
		cnt <= (sync_grant == 5'h00) ? 8'h00 : cnt + 8'h01;
	end
endmodule

// ### test/io_request_priority_sync_bench.sv
`timescale 1ns/10ps
module io_request_priority_sync_bench;
	import iorps_pkg::*;
	localparam int PC = 4;
	logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
	logic mem_wait = 0, data_channel_multicycle = 0, data_channel_single_out = 0, cpu_mem_busy = 0;
	logic [7:0] paddr = 8'h00, lat = 8'h03;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [4:0] want = 5'h00, req, done, sync_grant;
	logic [17:0] ac_word = 18'h2A5A5, device_word = 18'h1C3C3, io_bus_word, ac_return_word;
	logic [3:0] phase_onehot, p;
	logic io_sync_pulse, io_mem_request, io_mem_grant, cpu_mem_hold;
	int n_fail = 0, check_count = 0;
	iorps_top #(.PHASE_CYC(PC)) dut (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .data_channel_request(req[0]), .clock_request(req[1]),
		.auto_priority_interrupt_request(req[2]), .program_interrupt_request(req[3]),
		.io_instruction_request(req[4]), .xfer_done(done), .mem_wait, .data_channel_multicycle,
		.data_channel_single_out, .cpu_mem_busy, .ac_word, .device_word, .phase_onehot, .io_sync_pulse,
		.sync_grant, .io_mem_request, .io_mem_grant, .cpu_mem_hold, .io_bus_word, .ac_return_word);
	iorps_far_model pm (.ref_clk, .io_sync_pulse, .sync_grant, .want, .lat, .req, .done);
	initial forever #4 ref_clk = ~ref_clk;
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		check_count++;
		if (g !== x) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wait_g(input logic on);
		int i;
		for (i = 0; i < 300 && ((sync_grant !== 5'h00) !== on); i++) @(posedge ref_clk);
		if ((sync_grant !== 5'h00) !== on) begin
			n_fail++;
			$display("CHECK FAILED grant wait expected %b seen %b", on, !on);
		end
	endtask
	task automatic conclude();
		if (n_fail == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		conclude();
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		chk("phase", 4'h8, phase_onehot);
		sys_rst <= 0;
		apb(0, 8'h00, 0);
		chk("ctrl", 32'h00001F01, q);
		apb(0, 8'h10, 0);
		chk("slverr", 1, e);
		apb(1, 8'h00, 32'h00001F00);
		repeat (2) @(posedge ref_clk);
		p = phase_onehot;
		repeat (3 * PC) @(posedge ref_clk);
		chk("stopped", p, phase_onehot);
		apb(1, 8'h00, 32'h00001F01);
		want <= 5'h1F;
		for (int i = 0; i < 5; i++) begin
			wait_g(1);
			want <= 5'h00;
			chk("order", 5'h01 << i, sync_grant);
			wait_g(0);
		end
		cpu_mem_busy <= 1;
		lat <= 8'h28;
		want <= 5'h01;
		wait_g(1);
		want <= 5'h00;
		repeat (4) @(posedge ref_clk);
		chk("mem req", 1, io_mem_request);
		chk("mem early", 0, io_mem_grant);
		chk("cpu hold", 1, cpu_mem_hold);
		cpu_mem_busy <= 0;
		mem_wait <= 1;
		data_channel_multicycle <= 1;
		repeat (3) @(posedge ref_clk);
		chk("mem grant", 1, io_mem_grant);
		p = phase_onehot;
		repeat (3 * PC) @(posedge ref_clk);
		chk("held", p, phase_onehot);
		mem_wait <= 0;
		data_channel_multicycle <= 0;
		wait_g(0);
		lat <= 8'h08;
		want <= 5'h10;
		wait_g(1);
		want <= 5'h00;
		repeat (2) @(posedge ref_clk);
		chk("bus word", ac_word, io_bus_word);
		wait_g(0);
		chk("return", device_word, ac_return_word);
		want <= 5'h08;
		lat <= 8'h20;
		wait_g(1);
		want <= 5'h00;
		sys_rst <= 1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 0;
		chk("rst grant", 0, sync_grant);
		chk("rst phase", 4'h8, phase_onehot);
		wait_g(1);
		chk("regrant", 5'h08, sync_grant);
		apb(0, 8'h04, 0);
		chk("status sync", 5'h08, q[16:12]);
		apb(1, 8'h0C, 32'h00000008);
		repeat (2) @(posedge ref_clk);
		chk("abort", 0, sync_grant);
		wait_g(1);
		wait_g(0);
		apb(0, 8'h08, 0);
		chk("count", 2, q);
		conclude();
	end
endmodule
